// file: pkg/ebr_pkg.sv
// Operation
// - software selects ready input polarity
// - sync mode samples ready pin directly
// - async mode adds synchroniser, one extra wait
// - sample point from phases, differs by mode
// - ready inactive inserts one more wait state
// - ready active ends cycle, strobe released
// - ready ignored during programmed access waits
// - five ordered programmable bus cycle phases
// - ready may extend access phase, selectable
// - read data latched as strobe rises
package ebr_pkg;

    // register byte offsets
    localparam logic [7:0] EBR_CTRL_OFS   = 8'h00;
    localparam logic [7:0] EBR_TIMING_OFS = 8'h04;
    localparam logic [7:0] EBR_CMD_OFS    = 8'h08;
    localparam logic [7:0] EBR_STATUS_OFS = 8'h0c;
    localparam logic [7:0] EBR_RDATA_OFS  = 8'h10;

    // control field positions and reset values
    localparam int         EBR_CTRL_POL_BIT   = 0;
    localparam int         EBR_CTRL_ASYNC_BIT = 1;
    localparam int         EBR_CTRL_RDYEN_BIT = 2;
    localparam logic [2:0] EBR_CTRL_RST       = 3'h5;
    localparam int         EBR_CMD_DIR_BIT    = 0;
    localparam int         EBR_STAT_WAIT_POS  = 8;
    localparam int         EBR_STAT_STATE_POS = 4;

    // reference clock period, in ns and in system clock cycles
    localparam int EBR_CLK_NS      = 10;
    localparam int EBR_TCS_NS      = 20;
    localparam int EBR_TCS_CYCLES  = EBR_TCS_NS / EBR_CLK_NS;

    // phase durations, packed as held in the timing register
    typedef struct packed {
        logic [1:0] f;   // hold phase, 0..3 periods
        logic [4:0] e;   // access phase, value+1 periods
        logic       d;   // data setup phase, 0..1
        logic [1:0] c;   // command delay, 0..3
        logic       ab;  // address setup, value+1 periods
    } ebr_timing_t;

    localparam logic [10:0] EBR_TIMING_RST = 11'h010;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_AB   = 3'b001,
        ST_C    = 3'b010,
        ST_D    = 3'b011,
        ST_E    = 3'b100,
        ST_RDY  = 3'b101,
        ST_F    = 3'b110
    } ebr_state_t;

endpackage : ebr_pkg

// file: verilog/ebr_ready_sampler.sv
`timescale 1ns/100ps
`default_nettype none
module ebr_ready_sampler
    import ebr_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // reference clock enable and polarity
    input  wire logic tick,
    input  wire logic active_high,
    // external pin
    input  wire logic ready_pin,
    // sampled ready, already polarity corrected
    output logic      sync_ready,
    output logic      async_ready
);

    logic a1_reg, a2_reg, a3_reg, sync_reg, async_reg;
    logic a1_next, a2_next, a3_next, sync_next, async_next;

    // polarity is resolved at the sample in sync mode, and after the stage two and three agreement in async mode
    always_comb
    begin
        a1_next    = a1_reg;
        a2_next    = a2_reg;
        a3_next    = a3_reg;
        sync_next  = sync_reg;
        async_next = async_reg;
        if (tick)
        begin
            sync_next = (ready_pin == active_high);
            a1_next   = ready_pin;
            a2_next   = a1_reg;
            a3_next   = a2_reg;
            // a change counts only once stage two and three agree
            if (a2_reg == a3_reg)
            begin
                async_next = (a3_reg == active_high);
            end
        end
    end

    // all stages advance on the reference clock enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            a1_reg    <= 1'b0;
            a2_reg    <= 1'b0;
            a3_reg    <= 1'b0;
            sync_reg  <= 1'b0;
            async_reg <= 1'b0;
        end
        else
        begin
            a1_reg    <= a1_next;
            a2_reg    <= a2_next;
            a3_reg    <= a3_next;
            sync_reg  <= sync_next;
            async_reg <= async_next;
        end
    end

    assign sync_ready  = sync_reg;
    assign async_ready = async_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_sync_pol;
        // polarity taken at the sampling edge, a later control write must not matter
        tick && $stable(active_high) |=>
            sync_ready == ($past(ready_pin) == $past(active_high));
    endproperty
    a_sync_pol: assert property (p_sync_pol) else $error("sync ready polarity wrong");

    property p_async_agree;
        $changed(async_ready) |-> $past(a2_reg) == $past(a3_reg) && $past(tick);
    endproperty
    a_async_agree: assert property (p_async_agree) else $error("async ready without agree");

endmodule : ebr_ready_sampler
`default_nettype wire

// file: verilog/ebr_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module ebr_ctrl
    import ebr_pkg::*;
#(
    parameter int TCS_CYCLES = EBR_TCS_CYCLES
)
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // external bus
    input  wire logic        ext_ready_in,
    input  wire logic [15:0] ext_data_in,
    output logic             bus_reference_clock,
    output logic             ext_rd_n,
    output logic             ext_wr_n
);

    if (TCS_CYCLES < 2 || TCS_CYCLES > 255)
    begin : g_bad_tcs
        $error("TCS_CYCLES must lie in 2..255");
    end

    // next phase in order, zero-length phases skipped
    function automatic ebr_state_t next_phase(ebr_state_t s, ebr_timing_t t, logic rdy_en);
        unique case (s)
            ST_IDLE: next_phase = ST_AB;
            ST_AB:   next_phase = (t.c != 2'h0) ? ST_C : (t.d ? ST_D : ST_E);
            ST_C:    next_phase = t.d ? ST_D : ST_E;
            ST_D:    next_phase = ST_E;
            ST_E:    next_phase = rdy_en ? ST_RDY : ((t.f != 2'h0) ? ST_F : ST_IDLE);
            ST_RDY:  next_phase = (t.f != 2'h0) ? ST_F : ST_IDLE;
            default: next_phase = ST_IDLE;
        endcase
    endfunction : next_phase

    // periods left after the first one of a phase
    function automatic logic [4:0] phase_len(ebr_state_t s, ebr_timing_t t);
        unique case (s)
            ST_AB:   phase_len = {4'h0, t.ab};
            ST_C:    phase_len = {3'h0, 2'(t.c - 2'h1)};
            ST_E:    phase_len = t.e;
            ST_F:    phase_len = {3'h0, 2'(t.f - 2'h1)};
            default: phase_len = 5'h00;
        endcase
    endfunction : phase_len

    function automatic logic mapped(logic [7:0] a);
        mapped = (a == EBR_CTRL_OFS) || (a == EBR_TIMING_OFS) || (a == EBR_CMD_OFS) ||
                 (a == EBR_STATUS_OFS) || (a == EBR_RDATA_OFS);
    endfunction : mapped

    // reference clock divider; tick is the one-cycle period enable
    logic [7:0] div_reg, div_next;
    logic       ref_reg, ref_next, tick;

    assign tick = (div_reg == 8'(TCS_CYCLES - 1));

    always_comb
    begin
        div_next = tick ? 8'h00 : 8'(div_reg + 8'h01);
        ref_next = (div_next < 8'(TCS_CYCLES / 2));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_reg <= 8'h00;
            ref_reg <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            ref_reg <= ref_next;
        end
    end

    // ready input conditioning
    logic [2:0]  ctrl_reg, ctrl_next;
    logic        sync_rdy, async_rdy, rdy_ok, async_mode, rdy_en;

    assign async_mode = ctrl_reg[EBR_CTRL_ASYNC_BIT];
    assign rdy_en     = ctrl_reg[EBR_CTRL_RDYEN_BIT];
    assign rdy_ok     = async_mode ? async_rdy : sync_rdy;

    ebr_ready_sampler u_sampler (
        .pclk        (pclk),
        .presetn     (presetn),
        .tick        (tick),
        .active_high (ctrl_reg[EBR_CTRL_POL_BIT]),
        .ready_pin   (ext_ready_in),
        .sync_ready  (sync_rdy),
        .async_ready (async_rdy)
    );

    // apb slave: no wait cycles, answer always in the first access cycle
    ebr_timing_t timing_reg, timing_next;
    ebr_state_t  st_reg, st_next;
    logic [4:0]  cnt_reg, cnt_next;
    logic        first_reg, first_next, dir_reg, dir_next;
    logic [7:0]  waits_reg, waits_next;
    logic [15:0] rdata_reg, rdata_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next, pslverr_reg, pslverr_next;
    logic        rd_n_reg, rd_n_next, wr_n_reg, wr_n_next;
    logic        setup, wr_acc, start, leave, strobe_on;

    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pready_reg && pwrite && !pslverr_reg;
    assign start  = wr_acc && (paddr == EBR_CMD_OFS) && (st_reg == ST_IDLE);

    always_comb
    begin
        pready_next  = setup;
        pslverr_next = setup && !mapped(paddr);
        prdata_next  = prdata_reg;
        ctrl_next    = ctrl_reg;
        timing_next  = timing_reg;
        if (setup && !pwrite)
        begin
            unique case (paddr)
                EBR_CTRL_OFS:   prdata_next = {29'h0, ctrl_reg};
                EBR_TIMING_OFS: prdata_next = {21'h0, timing_reg};
                EBR_STATUS_OFS: prdata_next = {16'h0, waits_reg, 1'b0, st_reg,
                                               3'h0, (st_reg != ST_IDLE)};
                EBR_RDATA_OFS:  prdata_next = {16'h0, rdata_reg};
                default:        prdata_next = 32'h0;
            endcase
        end
        // timing changes only between cycles so a running cycle stays coherent
        if (wr_acc && paddr == EBR_CTRL_OFS)
        begin
            ctrl_next = pwdata[2:0];
        end
        if (wr_acc && paddr == EBR_TIMING_OFS && st_reg == ST_IDLE)
        begin
            timing_next = pwdata[10:0];
        end
    end

    // bus cycle sequencer, started by the command write, then advanced once per reference period
    always_comb
    begin
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        first_next = first_reg;
        waits_next = waits_reg;
        rdata_next = rdata_reg;
        dir_next   = dir_reg;
        leave      = 1'b0;
        if (st_reg == ST_IDLE)
        begin
            if (start)
            begin
                st_next    = ST_AB;
                cnt_next   = phase_len(ST_AB, timing_reg);
                dir_next   = pwdata[EBR_CMD_DIR_BIT];
                waits_next = 8'h00;
            end
        end
        else if (tick)
        begin
            if (cnt_reg != 5'h00)
            begin
                cnt_next = 5'(cnt_reg - 5'h01);
            end
            else if (st_reg == ST_RDY)
            begin
                // async mode spends its first sample on the synchroniser
                if (rdy_ok && !(first_reg && async_mode))
                begin
                    leave = 1'b1;
                end
                else
                begin
                    waits_next = 8'(waits_reg + 8'h01);
                    first_next = 1'b0;
                end
            end
            else
            begin
                leave = 1'b1;
            end
            if (leave)
            begin
                st_next    = next_phase(st_reg, timing_reg, rdy_en);
                cnt_next   = phase_len(st_next, timing_reg);
                first_next = 1'b1;
                // data latched on the edge that releases the read strobe
                if (!dir_reg && st_next != ST_RDY && (st_reg == ST_E || st_reg == ST_RDY))
                begin
                    rdata_next = ext_data_in;
                end
            end
        end
        strobe_on = (st_next == ST_E) || (st_next == ST_RDY);
        rd_n_next = !(strobe_on && !dir_next);
        wr_n_next = !(strobe_on && dir_next);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg    <= EBR_CTRL_RST;
            timing_reg  <= EBR_TIMING_RST;
            st_reg      <= ST_IDLE;
            cnt_reg     <= 5'h00;
            first_reg   <= 1'b1;
            dir_reg     <= 1'b0;
            waits_reg   <= 8'h00;
            rdata_reg   <= 16'h0000;
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            rd_n_reg    <= 1'b1;
            wr_n_reg    <= 1'b1;
        end
        else
        begin
            ctrl_reg    <= ctrl_next;
            timing_reg  <= timing_next;
            st_reg      <= st_next;
            cnt_reg     <= cnt_next;
            first_reg   <= first_next;
            dir_reg     <= dir_next;
            waits_reg   <= waits_next;
            rdata_reg   <= rdata_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            rd_n_reg    <= rd_n_next;
            wr_n_reg    <= wr_n_next;
        end
    end

    // outputs straight from flops
    assign prdata              = prdata_reg;
    assign pready              = pready_reg;
    assign pslverr             = pslverr_reg;
    assign bus_reference_clock = ref_reg;
    assign ext_rd_n            = rd_n_reg;
    assign ext_wr_n            = wr_n_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_mand_wait;
        st_reg == ST_E && cnt_reg != 5'h00 |=> st_reg == ST_E;
    endproperty
    a_mand_wait: assert property (p_mand_wait) else $error("access wait cut short");

    property p_not_ready;
        st_reg == ST_RDY && tick && !rdy_ok |=>
            st_reg == ST_RDY && waits_reg == $past(waits_reg) + 8'h01;
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("missing ready wait state");

    property p_ready_end;
        st_reg == ST_RDY && tick && rdy_ok && !first_reg |=>
            st_reg inside {ST_F, ST_IDLE} && ext_rd_n && ext_wr_n;
    endproperty
    a_ready_end: assert property (p_ready_end) else $error("ready did not end cycle");

    property p_async_extra;
        st_reg == ST_RDY && first_reg && tick && async_mode |=> st_reg == ST_RDY;
    endproperty
    a_async_extra: assert property (p_async_extra) else $error("async sample point too early");

    property p_order;
        st_reg == ST_AB |=> st_reg inside {ST_AB, ST_C, ST_D, ST_E};
    endproperty
    a_order: assert property (p_order) else $error("phase order broken");

    property p_no_ready_mode;
        st_reg == ST_E && cnt_reg == 5'h00 && tick && !rdy_en |=> st_reg != ST_RDY && ext_rd_n && ext_wr_n;
    endproperty
    a_no_ready_mode: assert property (p_no_ready_mode) else $error("ready used while disabled");

    property p_rdata_latch;
        $rose(ext_rd_n) |-> rdata_reg == $past(ext_data_in);
    endproperty
    a_rdata_latch: assert property (p_rdata_latch) else $error("read data not latched");

    property p_strobe_phase;
        !ext_rd_n || !ext_wr_n |-> st_reg inside {ST_E, ST_RDY};
    endproperty
    a_strobe_phase: assert property (p_strobe_phase) else $error("strobe outside access");

    c_read_done:  cover property ($rose(ext_rd_n));
    c_write_wait: cover property (!ext_wr_n && st_reg == ST_RDY && waits_reg > 8'h01);
    c_async_end:  cover property (async_mode && st_reg == ST_RDY ##1 st_reg != ST_RDY);

endmodule : ebr_ctrl
`default_nettype wire

// file: verification/ebr_ready_partner.sv
`timescale 1ns/100ps
`default_nettype none
module ebr_ready_partner
(
    // clocks
    input  wire logic        pclk,
    input  wire logic        bus_reference_clock,
    // behaviour chosen by the bench
    input  wire logic        active_high,
    input  wire logic [7:0]  delay,
    input  wire logic [15:0] data_val,
    // bus side
    input  wire logic        ext_rd_n,
    input  wire logic        ext_wr_n,
    output logic             ext_ready_in,
    output logic      [15:0] ext_data_in
);
    logic [7:0] cnt_reg;
    logic       act_reg;
    logic       busy_seen;

    initial
    begin
        cnt_reg     = 8'h00;
        act_reg     = 1'b0;
        ext_data_in = 16'h0000;
    end

    assign busy_seen    = !(ext_rd_n && ext_wr_n);
    // polarity applied at the pin, level only moves on reference edges
    assign ext_ready_in = active_high ? act_reg : !act_reg;

    // ready raised after delay periods, held until the strobe rises
    always @(posedge bus_reference_clock)
    begin
        if (!busy_seen)
        begin
            cnt_reg <= 8'h00;
            act_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_reg + 8'h01;
            if (cnt_reg + 8'h01 >= delay)
                act_reg <= 1'b1;
        end
    end

    // data only valid while read strobe low, otherwise a toggling pattern
    always @(posedge pclk)
    begin
        if (!ext_rd_n)
            ext_data_in <= data_val;
        else
            ext_data_in <= ~ext_data_in;
    end
endmodule : ebr_ready_partner
`default_nettype wire

// file: verification/ebr_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ebr_ctrl_tb_top
    import ebr_pkg::*;
;
    typedef struct packed {
        logic [2:0]  ctrl;
        logic [10:0] timing;
        logic        dir;
        logic [7:0]  delay;
        logic [15:0] data;
    } ebr_row_t;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, st;
    logic        ext_ready_in, bus_reference_clock, ext_rd_n, ext_wr_n, err;
    logic [15:0] ext_data_in;
    logic        pol, b0;
    logic [7:0]  delay;
    logic [15:0] data_val;
    int          num_errors, samples_checked, rd_lo, wr_lo, rd0, wr0, lo, emin;
    int          waits[6];
    ebr_row_t    rows[6];

    ebr_ctrl #(.TCS_CYCLES(2)) u_ebr_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_ready_in(ext_ready_in),
        .ext_data_in(ext_data_in), .bus_reference_clock(bus_reference_clock),
        .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n));

    ebr_ready_partner u_ebr_ready_partner (.pclk(pclk),
        .bus_reference_clock(bus_reference_clock), .active_high(pol), .delay(delay),
        .data_val(data_val), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
        .ext_ready_in(ext_ready_in), .ext_data_in(ext_data_in));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = !pclk;
    end

    // strobe low time in pclk cycles, read as differences
    always @(posedge pclk)
    begin
        rd_lo <= rd_lo + (ext_rd_n === 1'b0);
        wr_lo <= wr_lo + (ext_wr_n === 1'b0);
    end

    task automatic complete_run;
        if (num_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer, held until pready sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
        begin
            num_errors++;
            complete_run();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_idle;
        int n;
        for (n = 0; n < 200; n++)
        begin
            apb(1'b0, EBR_STATUS_OFS, 32'h0);
            if (rd[0] === 1'b0)
                break;
        end
        if (n == 200)
        begin
            num_errors++;
            complete_run();
        end
        st = rd;
    endtask : wait_idle

    initial
    begin
        num_errors = 0; samples_checked = 0; rd_lo = 0; wr_lo = 0;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; pol = 1'b1; delay = 8'h00; data_val = 16'h0;
        // ctrl, timing, dir, ready delay in periods, read data
        rows[0] = '{3'h5, 11'h010, 1'b0, 8'h00, 16'ha5c3};
        rows[1] = '{3'h7, 11'h010, 1'b0, 8'h00, 16'h5a3c};
        rows[2] = '{3'h4, 11'h030, 1'b1, 8'h06, 16'h0000};
        rows[3] = '{3'h6, 11'h7ff, 1'b0, 8'h02, 16'hffff};
        rows[4] = '{3'h1, 11'h020, 1'b0, 8'h09, 16'h8001};
        rows[5] = '{3'h5, 11'h000, 1'b0, 8'h04, 16'h0001};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, EBR_CTRL_OFS, 32'h0);
        chk(rd, {29'h0, EBR_CTRL_RST});
        apb(1'b0, EBR_TIMING_OFS, 32'h0);
        chk(rd, {21'h0, EBR_TIMING_RST});
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, err}, 32'h1);
        // reference clock toggles every pclk with a two-cycle period
        b0 = bus_reference_clock;
        @(posedge pclk);
        chk({31'h0, bus_reference_clock}, {31'h0, !b0});
        foreach (rows[i])
        begin
            pol      <= rows[i].ctrl[0];
            delay    <= rows[i].delay;
            data_val <= rows[i].data;
            apb(1'b1, EBR_CTRL_OFS, {29'h0, rows[i].ctrl});
            apb(1'b1, EBR_TIMING_OFS, {21'h0, rows[i].timing});
            rd0 = rd_lo;
            wr0 = wr_lo;
            apb(1'b1, EBR_CMD_OFS, {31'h0, rows[i].dir});
            wait_idle();
            waits[i] = int'(st[15:8]);
            lo   = rows[i].dir ? wr_lo - wr0 : rd_lo - rd0;
            emin = 2 * (int'(rows[i].timing[8:4]) + 1);
            chk(rows[i].dir ? rd_lo - rd0 : wr_lo - wr0, 32'h0);
            if (!rows[i].ctrl[2])
                chk(lo, emin);
            else
            begin
                chk({31'h0, lo >= emin}, 32'h1);
                chk({31'h0, lo >= 2 * int'(rows[i].delay)}, 32'h1);
                chk({31'h0, lo <= 2 * int'(rows[i].delay) + emin + 8}, 32'h1);
            end
            if (!rows[i].dir)
            begin
                apb(1'b0, EBR_RDATA_OFS, 32'h0);
                chk(rd[15:0], rows[i].data);
            end
        end
        chk({31'h0, waits[1] > waits[0]}, 32'h1);
        // reset in mid-cycle drops the strobe at once
        apb(1'b1, EBR_CMD_OFS, 32'h0);
        repeat (6) @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        chk({ext_rd_n, ext_wr_n}, 32'h3);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, EBR_STATUS_OFS, 32'h0);
        chk(rd[0], 32'h0);
        complete_run();
    end
endmodule : ebr_ctrl_tb_top
`default_nettype wire
